/* common/pad_cell_map.vh */
// Named constants for the configurable pad cell.
`ifndef PAD_CELL_MAP_VH
`define PAD_CELL_MAP_VH

// ****************************************************************
// Output enable modes
// ****************************************************************
`define OE_MODE_OFF         2'h0
`define OE_MODE_ON          2'h1
`define OE_MODE_CTRL        2'h2

// ****************************************************************
// Configuration reset values (blank device)
// ****************************************************************
`define RST_PULLUP          1'h1
`define RST_OE_MODE         2'h0
`define RST_FLAG            1'h0
`define RST_RESET_N         1'h1

// ****************************************************************
// Soft startup timing
// ****************************************************************
`define SOFT_HOLD_NS        200
`define CORE_CLK_MHZ        25
`define NS_PER_US           1000
`define SOFT_CNT_W          4

`endif

/* logic/pad_cell.v */
// Configurable pad cell sitting between a package pin and the routing fabric.
//
// What this block does
// (RULE1) Two shared clock lines per edge, polarity programmed per line.
// (RULE2) Rising-edge line makes latches low-transparent; falling makes them high-transparent.
// (RULE3) Buffered pin feeds an input element configured as flip-flop or latch.
// (RULE4) All storage cleared during configuration or while chip reset is low.
// (RULE5) Raw pin value and stored value both go to the routing together.
// (RULE6) Pull-up only on a pin used as input, never on an output.
// (RULE7) Pull-up enabled by default so open inputs sit high.
// (RULE8) Output data comes from drv_val, direct or through the output register.
// (RULE9) One configuration bit optionally inverts the output data.
// (RULE10) Buffer forced on, forced off, or controlled by hiz_req (high floats).
// (RULE11) Extra bit inverts tri-state sense into an active-high output enable.
// (RULE12) Output register is rising-edge, clocked by either invertible edge line.
// (RULE13) Fabric ties data and tri-state together to get an open-drain pin.
// (RULE14) Each output selects fast or slew-limited transitions.
// (RULE15) First output enabling after configuration is slew-limited, then per setting.
// (RULE16) Fabric adds an inverter when one line drives both flip-flops and latches.
// (RULE17) Configuration bits stay constant in user mode, changing only on reconfiguration.
`timescale 1ns/10ps
`include "pad_cell_map.vh"
`default_nettype none

module pad_cell #(
    parameter SOFT_HOLD_NS = `SOFT_HOLD_NS
) (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       chip_reset_n,
    input  wire       config_busy,
    input  wire       edge_clk_a,
    input  wire       edge_clk_b,
    input  wire       cfg_clk_inv_a,
    input  wire       cfg_clk_inv_b,
    input  wire       cfg_in_clk_sel,
    input  wire       cfg_in_latch,
    input  wire       cfg_out_clk_sel,
    input  wire       cfg_out_reg,
    input  wire       cfg_out_inv,
    input  wire [1:0] cfg_oe_mode,
    input  wire       cfg_oe_inv,
    input  wire       cfg_fast_slew,
    input  wire       cfg_pullup,
    input  wire       pad_in,
    input  wire       drv_val,
    input  wire       hiz_req,
    output reg        pad_out,
    output reg        pad_oe,
    output reg        pad_pullup,
    output reg        pad_slow,
    output reg        pad_raw,
    output reg        pad_sampled
);

    // Cycles the soft startup keeps the slow edge after the first enable.
    localparam SOFT_CYC_RAW = (SOFT_HOLD_NS * `CORE_CLK_MHZ + `NS_PER_US - 1) / `NS_PER_US;
    localparam SOFT_CYC     = (SOFT_CYC_RAW < 1) ? 1 : SOFT_CYC_RAW;
    // The count is cut to the counter width on purpose; the default needs three bits.
    localparam [31:0] SOFT_LAST_W = SOFT_CYC - 1;
    localparam [`SOFT_CNT_W-1:0] SOFT_LAST = SOFT_LAST_W[`SOFT_CNT_W-1:0];
    localparam NSYNC = 4;
    localparam [NSYNC-1:0] SYNC_INIT = {`RST_FLAG, `RST_FLAG, `RST_RESET_N, `RST_FLAG};

    // Soft startup states.
    localparam [1:0] ST_CONFIG = 2'h0;
    localparam [1:0] ST_WAIT   = 2'h1;
    localparam [1:0] ST_HOLD   = 2'h2;
    localparam [1:0] ST_USER   = 2'h3;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Index 0 pad, 1 chip reset, 2 edge line a, 3 edge line b.
    wire [NSYNC-1:0] sync_raw = {edge_clk_b, edge_clk_a, chip_reset_n, pad_in};
    reg  [NSYNC-1:0] sync1_q;
    reg  [NSYNC-1:0] sync2_q;
    reg  [NSYNC-1:0] sync3_q;
    reg  [NSYNC-1:0] stable_q;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            // A change is accepted only once stages two and three agree, which filters runts.
            always @(posedge core_clk) begin
                if (rst) begin
                    sync1_q[gi]  <= SYNC_INIT[gi];
                    sync2_q[gi]  <= SYNC_INIT[gi];
                    sync3_q[gi]  <= SYNC_INIT[gi];
                    stable_q[gi] <= SYNC_INIT[gi];
                end else begin
                    sync1_q[gi] <= sync_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        stable_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Configuration store
    // ****************************************************************
    reg       clk_inv_a_q;
    reg       clk_inv_b_q;
    reg       in_clk_sel_q;
    reg       in_latch_q;
    reg       out_clk_sel_q;
    reg       out_reg_q;
    reg       out_inv_q;
    reg [1:0] oe_mode_q;
    reg       oe_inv_q;
    reg       fast_slew_q;
    reg       pullup_q;

    // Option bits load only while configuring, so user-mode wiggles on the ports do nothing.
    always @(posedge core_clk) begin
        if (rst) begin
            clk_inv_a_q   <= `RST_FLAG;
            clk_inv_b_q   <= `RST_FLAG;
            in_clk_sel_q  <= `RST_FLAG;
            in_latch_q    <= `RST_FLAG;
            out_clk_sel_q <= `RST_FLAG;
            out_reg_q     <= `RST_FLAG;
            out_inv_q     <= `RST_FLAG;
            oe_mode_q     <= `RST_OE_MODE;
            oe_inv_q      <= `RST_FLAG;
            fast_slew_q   <= `RST_FLAG;
            pullup_q      <= `RST_PULLUP;                    // see RULE7
        end else if (config_busy) begin                      // see RULE17
            clk_inv_a_q   <= cfg_clk_inv_a;
            clk_inv_b_q   <= cfg_clk_inv_b;
            in_clk_sel_q  <= cfg_in_clk_sel;
            in_latch_q    <= cfg_in_latch;
            out_clk_sel_q <= cfg_out_clk_sel;
            out_reg_q     <= cfg_out_reg;
            out_inv_q     <= cfg_out_inv;
            oe_mode_q     <= cfg_oe_mode;
            oe_inv_q      <= cfg_oe_inv;
            fast_slew_q   <= cfg_fast_slew;
            pullup_q      <= cfg_pullup;
        end
    end

    // ****************************************************************
    // Edge clock lines
    // ****************************************************************
    // Polarity is applied once per line, so every element on a line sees the same sense.
    wire line_a = stable_q[2] ^ clk_inv_a_q;                 // see RULE1
    wire line_b = stable_q[3] ^ clk_inv_b_q;                 // see RULE1
    reg  line_a_prev_q;
    reg  line_b_prev_q;

    // Previous line levels give the rising-edge events.
    always @(posedge core_clk) begin
        if (rst) begin
            line_a_prev_q <= `RST_FLAG;
            line_b_prev_q <= `RST_FLAG;
        end else begin
            line_a_prev_q <= line_a;
            line_b_prev_q <= line_b;
        end
    end

    wire rise_a  = line_a & ~line_a_prev_q;
    wire rise_b  = line_b & ~line_b_prev_q;
    wire in_line = in_clk_sel_q ? line_b : line_a;
    wire in_rise = in_clk_sel_q ? rise_b : rise_a;
    wire out_rise = out_clk_sel_q ? rise_b : rise_a;          // see RULE12

    // Storage is cleared for the whole configuration and for a low chip reset.
    wire store_clr = config_busy | ~stable_q[1];              // see RULE4

    // ****************************************************************
    // Input storage element and output register
    // ****************************************************************
    reg in_store_q;
    reg out_store_q;

    // The latch is transparent while its line is low, the mirror of a rising-edge flop.
    always @(posedge core_clk) begin
        if (rst || store_clr) begin                           // see RULE4
            in_store_q  <= `RST_FLAG;
            out_store_q <= `RST_FLAG;
        end else begin
            if (in_latch_q ? ~in_line : in_rise) begin        // see RULE2 see RULE3
                in_store_q <= stable_q[0];
            end
            if (out_rise) begin                               // see RULE12
                out_store_q <= drv_val;
            end
        end
    end

    // ****************************************************************
    // Output path
    // ****************************************************************
    reg out_d;
    reg oe_d;

    // Data select and inversion, then the enable decode.
    always @* begin
        out_d = (out_reg_q ? out_store_q : drv_val) ^ out_inv_q;   // see RULE8 see RULE9
        case (oe_mode_q)
            `OE_MODE_OFF:  oe_d = 1'b0;                       // see RULE10
            `OE_MODE_ON:   oe_d = 1'b1;                       // see RULE10
            `OE_MODE_CTRL: oe_d = ~(hiz_req ^ oe_inv_q);      // see RULE10 see RULE11
            default:       oe_d = 1'b0;
        endcase
        // The pins stay floating while the device is configuring.
        if (config_busy) begin
            oe_d = 1'b0;
        end
    end

    // ****************************************************************
    // Soft startup
    // ****************************************************************
    reg [1:0]            soft_st_q;
    reg [`SOFT_CNT_W-1:0] soft_cnt_q;

    // The slow edge is held through the first enable so all pins do not slam at once.
    always @(posedge core_clk) begin
        if (rst || config_busy) begin
            soft_st_q  <= ST_CONFIG;
            soft_cnt_q <= {`SOFT_CNT_W{1'b0}};
        end else begin
            case (soft_st_q)
                ST_CONFIG: begin
                    soft_st_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (oe_d) begin                           // see RULE15
                        soft_st_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (soft_cnt_q == SOFT_LAST) begin
                        soft_st_q <= ST_USER;
                    end else begin
                        soft_cnt_q <= soft_cnt_q + 1'b1;
                    end
                end
                ST_USER: begin
                    soft_st_q <= ST_USER;
                end
                default: begin
                    soft_st_q <= ST_CONFIG;
                end
            endcase
        end
    end

    // ****************************************************************
    // Registered pin and fabric outputs
    // ****************************************************************
    // Every output is a flop, which costs one cycle of latency on each path.
    always @(posedge core_clk) begin
        if (rst) begin
            pad_out     <= `RST_FLAG;
            pad_oe      <= `RST_FLAG;
            pad_pullup  <= `RST_PULLUP;                       // see RULE7
            pad_slow    <= 1'b1;
            pad_raw     <= `RST_FLAG;
            pad_sampled <= `RST_FLAG;
        end else begin
            pad_out     <= out_d;
            pad_oe      <= oe_d;
            pad_pullup  <= pullup_q & (oe_mode_q == `OE_MODE_OFF);    // see RULE6
            pad_slow    <= ~fast_slew_q | (soft_st_q != ST_USER);     // see RULE14 see RULE15
            pad_raw     <= stable_q[0];                       // see RULE5
            pad_sampled <= in_store_q;                        // see RULE5
        end
    end

endmodule // pad_cell

`default_nettype wire

/* test/pad_cell_sva.sv */
// Port-level assertions for the configurable pad cell.
`timescale 1ns/10ps
`default_nettype none
`include "pad_cell_map.vh"
module pad_cell_sva (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       chip_reset_n,
    input wire logic       config_busy,
    input wire logic       cfg_out_reg,
    input wire logic       cfg_out_inv,
    input wire logic [1:0] cfg_oe_mode,
    input wire logic       cfg_oe_inv,
    input wire logic       pad_in,
    input wire logic       drv_val,
    input wire logic       hiz_req,
    input wire logic       pad_out,
    input wire logic       pad_oe,
    input wire logic       pad_pullup,
    input wire logic       pad_slow,
    input wire logic       pad_raw,
    input wire logic       pad_sampled
);
    // The cfg ports stand for the stored set only while the bench holds them after loading.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_pull_only_input: assert property (!(pad_pullup && pad_oe))
        else $error("pull-up on a driven pin");
    a_reset_values: assert property (disable iff (1'b0) rst |=> !pad_oe && pad_pullup
        && pad_slow && !pad_out && !pad_raw && !pad_sampled) else $error("bad reset values");
    a_busy_no_drive: assert property (config_busy |=> !pad_oe)
        else $error("pin driven while loading");
    a_chip_reset_clears: assert property (!chip_reset_n [*7] |-> !pad_sampled)
        else $error("input element not cleared");
    a_oe_ctrl_sense: assert property (!config_busy && cfg_oe_mode == `OE_MODE_CTRL
        |=> pad_oe == ($past(hiz_req) ~^ $past(cfg_oe_inv))) else $error("enable sense wrong");
    a_direct_data: assert property (!config_busy && cfg_oe_mode == `OE_MODE_ON
        && !cfg_out_reg |=> pad_oe && pad_out == ($past(drv_val) ^ $past(cfg_out_inv)))
        else $error("bad data");
    a_soft_start: assert property ($fell(config_busy) |=> pad_slow [*5])
        else $error("startup not slew limited");
    a_raw_tracks: assert property (($stable(pad_in) && !rst) [*8] |-> pad_raw == pad_in)
        else $error("raw pin value stale");
endmodule // pad_cell_sva
bind pad_cell pad_cell_sva pad_cell_sva_inst (
    .core_clk(core_clk), .rst(rst), .chip_reset_n(chip_reset_n), .config_busy(config_busy),
    .cfg_out_reg(cfg_out_reg), .cfg_out_inv(cfg_out_inv), .cfg_oe_mode(cfg_oe_mode),
    .cfg_oe_inv(cfg_oe_inv), .pad_in(pad_in), .drv_val(drv_val), .hiz_req(hiz_req),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pad_slow(pad_slow),
    .pad_raw(pad_raw), .pad_sampled(pad_sampled)
);
`default_nettype wire

/* test/pad_board.sv */
// Board-side model of the package pin.
`timescale 1ns/10ps
`default_nettype none
module pad_board (
    input  wire logic core_clk,
    input  wire logic pad_out,
    input  wire logic pad_oe,
    input  wire logic pad_pullup,
    input  wire logic ext_en,
    input  wire logic ext_val,
    output var  logic pin_level
);
    logic float_q = 1'b0;
    // An open pin with no pull-up wanders, so no stale level can pass for a real one.
    always @(posedge core_clk) begin
        float_q <= ~float_q;
    end
    // The cell wins when it drives; the pull-up holds an open pin high.
    always_comb begin
        if (pad_oe) begin
            pin_level = pad_out;
        end else if (ext_en) begin
            pin_level = ext_val;
        end else if (pad_pullup) begin
            pin_level = 1'b1;
        end else begin
            pin_level = float_q;
        end
    end
endmodule // pad_board
`default_nettype wire

/* test/pad_cell_tb.sv */
// Self-checking bench for the configurable pad cell.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch %s expected %b seen %b", nm, exp, got); end end
module pad_cell_tb;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        chip_reset_n = 1'b1;
    logic        config_busy = 1'b0;
    logic [1:0]  line = 2'b00;
    logic [11:0] cfg = 12'h001;
    logic        drv_val = 1'b0;
    logic        hiz_req = 1'b0;
    logic        ext_en = 1'b0;
    logic        ext_val = 1'b0;
    logic        e;
    logic        pin_level, pad_out, pad_oe, pad_pullup, pad_slow, pad_raw, pad_sampled;
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;
    pad_cell #(.SOFT_HOLD_NS(200)) pad_cell_inst (
        .core_clk(core_clk), .rst(rst), .chip_reset_n(chip_reset_n), .config_busy(config_busy),
        .edge_clk_a(line[0]), .edge_clk_b(line[1]), .cfg_clk_inv_a(cfg[11]),
        .cfg_clk_inv_b(cfg[10]), .cfg_in_clk_sel(cfg[9]), .cfg_in_latch(cfg[8]),
        .cfg_out_clk_sel(cfg[7]), .cfg_out_reg(cfg[6]), .cfg_out_inv(cfg[5]),
        .cfg_oe_mode(cfg[4:3]), .cfg_oe_inv(cfg[2]), .cfg_fast_slew(cfg[1]), .cfg_pullup(cfg[0]),
        .pad_in(pin_level), .drv_val(drv_val), .hiz_req(hiz_req), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pad_slow(pad_slow), .pad_raw(pad_raw),
        .pad_sampled(pad_sampled));
    pad_board pad_board_inst (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level));
    always #20 core_clk = ~core_clk;
    // Cycle ceiling; the whole sequence needs well under a third of it.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Options are only taken while loading, so they change together with the busy flag.
    task automatic configure(input logic [11:0] c);
        cfg <= c;
        config_busy <= 1'b1;
        cyc(2);
        config_busy <= 1'b0;
        cyc(1);
    endtask
    // Edge lines pass a synchroniser, so each level is held ten cycles.
    task automatic pulse(input int b);
        line[b] <= 1'b1;
        cyc(10);
        line[b] <= 1'b0;
        cyc(10);
    endtask
    task automatic report(input string s);
        $display("test %s ended: %0d checks, %0d mismatches", s, checked, err_count);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d, err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        cyc(6);
        rst <= 1'b0;
        cyc(1);
        `CHK("pad_slow", 1'b1, pad_slow)
        // Input element on each line, as flop or latch, in both polarities.
        ext_en <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            ext_val <= 1'b0;
            configure({k[2], k[2], k[0], k[1], 8'h01});
            cyc(10);
            ext_val <= 1'b1;
            line[~k[0]] <= 1'b1;
            cyc(10);
            line[~k[0]] <= 1'b0;
            cyc(10);
            `CHK("sampled_idle", k[1] & ~k[2], pad_sampled)
            line[k[0]] <= 1'b1;
            cyc(10);
            `CHK("sampled_rise", k[1] | ~k[2], pad_sampled)
            line[k[0]] <= 1'b0;
            cyc(10);
            `CHK("sampled_fall", 1'b1, pad_sampled)
            `CHK("pad_raw", 1'b1, pad_raw)
        end
        chip_reset_n <= 1'b0;
        cyc(8);
        `CHK("sampled_cleared", 1'b0, pad_sampled)
        chip_reset_n <= 1'b1;
        ext_en <= 1'b0;
        report("input");
        // Every enable mode and sense, with data and control tied as an open drain.
        for (int k = 0; k < 16; k++) begin
            configure({7'h00, k[1:0], k[2], 2'b01});
            hiz_req <= k[3];
            drv_val <= k[3];
            cyc(3);
            e = (k[1:0] == 1) | ((k[1:0] == 2) & (k[3] ~^ k[2]));
            `CHK("pad_oe", e, pad_oe)
            `CHK("pad_pullup", k[1:0] == 2'b00, pad_pullup)
            if (e) `CHK("pad_out", k[3], pad_out)
        end
        // The last mode leaves the pin floating, so return to a pulled-up input first.
        configure(12'h001);
        cyc(8);
        `CHK("pad_raw_pulled", 1'b1, pad_raw)
        // Direct and registered data, plain and inverted, clocked from either line.
        for (int k = 0; k < 4; k++) begin
            configure({4'h0, k[1], k[0], k[1], 2'h1, 3'h0});
            drv_val <= 1'b1;
            cyc(4);
            `CHK("pad_out_early", k[0] ? k[1] : ~k[1], pad_out)
            pulse(k[1]);
            `CHK("pad_out_clocked", ~k[1], pad_out)
        end
        configure({7'h00, 2'h1, 3'h2});
        `CHK("slow_at_start", 1'b1, pad_slow)
        cyc(30);
        `CHK("slow_fast", 1'b0, pad_slow)
        cfg <= 12'h000;
        cyc(5);
        `CHK("oe_kept", 1'b1, pad_oe)
        configure({7'h00, 2'h1, 3'h0});
        cyc(30);
        `CHK("slow_limited", 1'b1, pad_slow)
        report("output");
        tally_and_finish();
    end
endmodule // pad_cell_tb
`default_nettype wire
